// >>> design/decel_overvoltage_guard.sv
// Deceleration overvoltage guard: AHB-Lite registers and ramp control
`timescale 1ns/100ps
module decel_overvoltage_guard
    import ovp_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    // Drive class strap, high for 400 V class
    input wire logic CLASS_400,
    // Ramp generator and DC link measurement
    input wire logic DECEL_ACTIVE,
    input wire logic VDC_VALID,
    input wire logic [10:0] VDC,
    // Ramp steering
    output logic RAMP_HOLD,
    output logic RAMP_ACCEL,
    output logic [11:0] ACCEL_RATE,
    output logic signed [15:0] FREQ_LIFT,
    output logic GUARD_ACTIVE
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ovp_pi_if pi_bus ();

    mode_type mode;
    state_type state;
    state_type next_state;
    logic [10:0] level;
    logic [11:0] accel_rate;
    logic [7:0] gain;
    logic [15:0] itime;
    logic strap_done;
    logic over_level;
    logic below_level;
    logic armed;
    logic dp_write;
    logic [7:0] dp_addr;
    logic take;
    logic [10:0] level_min;
    logic [10:0] level_max;
    logic [10:0] level_wr;
    logic [11:0] accel_wr;
    logic [31:0] next_rdata;
    logic [10:0] last_vdc;

    // ------------------------------------------------------------
    // AHB-Lite address phase capture
    // ------------------------------------------------------------
    // Zero-wait slave: every transfer completes in one data phase
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign take = HSEL && HREADY && HTRANS[1];

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            dp_write <= 1'b0;
            dp_addr <= '0;
        end else if (HREADY) begin
            dp_write <= take && HWRITE;
            dp_addr <= HADDR;
        end
    end

    // ------------------------------------------------------------
    // Write value conditioning
    // ------------------------------------------------------------
    // Out-of-range writes clamp rather than fault, so a bad value
    // can never disable the guard by accident
    always_comb begin
        level_min = CLASS_400 ? LEVEL_MIN_400 : LEVEL_MIN_200;
        level_max = CLASS_400 ? LEVEL_MAX_400 : LEVEL_MAX_200;
        if (HWDATA[10:0] < level_min) begin
            level_wr = level_min;
        end else if (HWDATA[10:0] > level_max || HWDATA[31:11] != '0) begin
            level_wr = level_max;
        end else begin
            level_wr = HWDATA[10:0];
        end
        if (HWDATA[11:0] < ACCEL_MIN) begin
            accel_wr = ACCEL_MIN;
        end else if (HWDATA[11:0] > ACCEL_MAX || HWDATA[31:12] != '0) begin
            accel_wr = ACCEL_MAX;
        end else begin
            accel_wr = HWDATA[11:0];
        end
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    // Code 11 is not a mode; such a write leaves the mode unchanged
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode <= mode_type'(MODE_DEF);
        end else if (dp_write && dp_addr == OFS_MODE) begin
            if (HWDATA[1:0] != 2'b11) begin
                mode <= mode_type'(HWDATA[1:0]);
            end
        end
    end

    // ------------------------------------------------------------
    // Protection level, default taken from the class strap
    // ------------------------------------------------------------
    // The strap is caught on the first edge after reset release
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_done <= 1'b0;
            level <= LEVEL_DEF_200;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            level <= CLASS_400 ? LEVEL_DEF_400 : LEVEL_DEF_200;
        end else if (dp_write && dp_addr == OFS_LEVEL) begin
            level <= level_wr;
        end
    end

    // ------------------------------------------------------------
    // Acceleration rate, gain and integral time
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            accel_rate <= ACCEL_DEF;
        end else if (dp_write && dp_addr == OFS_ACCEL) begin
            accel_rate <= accel_wr;
        end
    end

    // Full 8-bit range is legal: 0.00 to 2.55
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            gain <= GAIN_DEF;
        end else if (dp_write && dp_addr == OFS_GAIN) begin
            gain <= HWDATA[7:0];
        end
    end

    // Full 16-bit range is legal: 0.000 to 65.535 s
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            itime <= ITIME_DEF;
        end else if (dp_write && dp_addr == OFS_ITIME) begin
            itime <= HWDATA[15:0];
        end
    end

    // ------------------------------------------------------------
    // Read data, registered in the address phase
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        if (HADDR == OFS_MODE) begin
            next_rdata = {30'h0, mode};
        end else if (HADDR == OFS_LEVEL) begin
            next_rdata = {21'h0, level};
        end else if (HADDR == OFS_ACCEL) begin
            next_rdata = {20'h0, accel_rate};
        end else if (HADDR == OFS_GAIN) begin
            next_rdata = {24'h0, gain};
        end else if (HADDR == OFS_ITIME) begin
            next_rdata = {16'h0, itime};
        end else if (HADDR == OFS_STATUS) begin
            next_rdata = {pi_bus.lift, last_vdc, 1'b0,
                          RAMP_ACCEL, RAMP_HOLD, state};
        end
    end

    // Unmapped offsets read as zero
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            HRDATA <= '0;
        end else if (take && !HWRITE) begin
            HRDATA <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Voltage comparison
    // ------------------------------------------------------------
    // Compare only when enabled and a decel ramp is running
    assign armed = DECEL_ACTIVE && mode != MODE_OFF;
    assign over_level = VDC > level;
    assign below_level = VDC < level;

    // Last sample seen while armed, for software monitoring
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            last_vdc <= '0;
        end else if (armed && VDC_VALID) begin
            last_vdc <= VDC;
        end
    end

    // ------------------------------------------------------------
    // Guard state machine
    // ------------------------------------------------------------
    // Equal voltage keeps the current direction to avoid chatter
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (armed) begin
                    next_state = ST_WATCH;
                end
            end
            ST_WATCH: begin
                if (!armed) begin
                    next_state = ST_IDLE;
                end else if (mode == MODE_CONST_V) begin
                    next_state = ST_REGULATE;
                end else if (VDC_VALID && over_level) begin
                    next_state = ST_BOOST;
                end
            end
            ST_REGULATE: begin
                if (!armed || mode != MODE_CONST_V) begin
                    next_state = ST_IDLE;
                end
            end
            ST_BOOST: begin
                if (!armed || mode != MODE_ACCEL) begin
                    next_state = ST_IDLE;
                end else if (VDC_VALID && below_level) begin
                    next_state = ST_WATCH;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // PI loop hookup
    // ------------------------------------------------------------
    // Loop is cleared outside regulation so each decel starts fresh
    assign pi_bus.clear = state != ST_REGULATE;
    assign pi_bus.sample = state == ST_REGULATE && VDC_VALID;
    assign pi_bus.error = 12'($signed({1'b0, VDC}) - $signed({1'b0, level}));
    assign pi_bus.gain = gain;
    assign pi_bus.itime = itime;

    ovp_pi_loop u_pi (
        .clk(CLK),
        .rst_b(RST_B),
        .pi(pi_bus)
    );

    // ------------------------------------------------------------
    // Ramp steering outputs
    // ------------------------------------------------------------
    // Hold/accel never time out: the ramp may take as long as the
    // voltage demands, so a low level can stall the stop entirely
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RAMP_HOLD <= 1'b0;
            RAMP_ACCEL <= 1'b0;
            FREQ_LIFT <= '0;
            GUARD_ACTIVE <= 1'b0;
        end else begin
            GUARD_ACTIVE <= next_state != ST_IDLE;
            RAMP_ACCEL <= next_state == ST_BOOST;
            // Positive lift slows the decel ramp while the link is high
            if (next_state == ST_REGULATE) begin
                FREQ_LIFT <= pi_bus.lift;
                RAMP_HOLD <= pi_bus.lift > 16'sd0;
            end else begin
                FREQ_LIFT <= '0;
                RAMP_HOLD <= next_state == ST_BOOST;
            end
        end
    end

    // Rate applies only while boosting, otherwise reads zero
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ACCEL_RATE <= '0;
        end else if (next_state == ST_BOOST) begin
            ACCEL_RATE <= accel_rate;
        end else begin
            ACCEL_RATE <= '0;
        end
    end

endmodule

// >>> common/ovp_pkg.sv
// Constants and types for the deceleration overvoltage guard
package ovp_pkg;

    // ------------------------------------------------------------
    // Clock and sampling
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int SAMPLE_PERIOD_MS = 1;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_LEVEL = 8'h04;
    localparam logic [7:0] OFS_ACCEL = 8'h08;
    localparam logic [7:0] OFS_GAIN = 8'h0C;
    localparam logic [7:0] OFS_ITIME = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ------------------------------------------------------------
    // Protection modes and guard states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_CONST_V = 2'b01,
        MODE_ACCEL = 2'b10
    } mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WATCH = 2'b01,
        ST_REGULATE = 2'b10,
        ST_BOOST = 2'b11
    } state_type;

    // ------------------------------------------------------------
    // Ranges and reset values (volts, 10 ms, 0.01, ms)
    // ------------------------------------------------------------
    localparam logic [10:0] LEVEL_MIN_200 = 11'd330;
    localparam logic [10:0] LEVEL_MAX_200 = 11'd390;
    localparam logic [10:0] LEVEL_DEF_200 = 11'd380;
    localparam logic [10:0] LEVEL_MIN_400 = 11'd660;
    localparam logic [10:0] LEVEL_MAX_400 = 11'd780;
    localparam logic [10:0] LEVEL_DEF_400 = 11'd760;
    localparam logic [11:0] ACCEL_MIN = 12'd10;
    localparam logic [11:0] ACCEL_MAX = 12'd3000;
    localparam logic [11:0] ACCEL_DEF = 12'd100;
    localparam logic [7:0] GAIN_DEF = 8'd50;
    localparam logic [15:0] ITIME_DEF = 16'd60;
    localparam logic [1:0] MODE_DEF = 2'b01;

    // Integrator saturation in volt-samples, then lift output saturation
    localparam logic signed [23:0] ACC_LIMIT = 24'sd1000000;
    localparam logic signed [15:0] LIFT_LIMIT = 16'sd32767;

endpackage

// >>> common/ovp_pi_if.sv
// Signals between the guard controller and its PI loop
`timescale 1ns/100ps
interface ovp_pi_if;
    logic sample;
    logic clear;
    logic signed [11:0] error;
    logic [7:0] gain;
    logic [15:0] itime;
    logic signed [15:0] lift;

    modport ctrl (output sample, clear, error, gain, itime, input lift);
    modport loop (input sample, clear, error, gain, itime, output lift);
endinterface

// >>> design/ovp_pi_loop.sv
// Proportional-plus-integral loop for DC link voltage regulation
`timescale 1ns/100ps
module ovp_pi_loop
    import ovp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Loop signals
    ovp_pi_if.loop pi
);

    logic signed [23:0] acc;
    logic signed [24:0] next_acc;
    logic signed [23:0] integral;
    logic signed [24:0] sum;
    logic signed [34:0] scaled;
    logic signed [15:0] next_lift;

    // ------------------------------------------------------------
    // Integrator, one step per sample, clamped against windup
    // ------------------------------------------------------------
    always_comb begin
        next_acc = 25'(acc) + 25'(pi.error);
        if (next_acc > 25'(ACC_LIMIT)) begin
            next_acc = 25'(ACC_LIMIT);
        end else if (next_acc < -25'(ACC_LIMIT)) begin
            next_acc = -25'(ACC_LIMIT);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= '0;
        end else if (pi.clear) begin
            acc <= '0;
        end else if (pi.sample) begin
            acc <= next_acc[23:0];
        end
    end

    // ------------------------------------------------------------
    // Output: gain/100 * (error + acc * Ts / Ti); Ti of zero drops I
    // ------------------------------------------------------------
    always_comb begin
        if (pi.itime == 16'h0000) begin
            integral = '0;
        end else begin
            integral = 24'(acc * SAMPLE_PERIOD_MS / $signed({1'b0, pi.itime}));
        end
        sum = 25'(pi.error) + 25'(integral);
        scaled = 35'(sum * $signed({1'b0, pi.gain}) / 100);
        if (scaled > 35'(LIFT_LIMIT)) begin
            next_lift = LIFT_LIMIT;
        end else if (scaled < -35'(LIFT_LIMIT)) begin
            next_lift = -LIFT_LIMIT;
        end else begin
            next_lift = scaled[15:0];
        end
    end

    // Lift only updates on a sample or is zeroed by clear, so it is steady between periods
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pi.lift <= '0;
        end else if (pi.clear) begin
            pi.lift <= '0;
        end else if (pi.sample) begin
            pi.lift <= next_lift;
        end
    end

endmodule

// >>> sim/decel_overvoltage_guard_props.sv
// Concurrent checks on the ports of the deceleration overvoltage guard
`timescale 1ns/100ps
module decel_overvoltage_guard_props
    import ovp_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Bus answer
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // Ramp link inputs
    input wire logic DECEL_ACTIVE,
    input wire logic VDC_VALID,
    input wire logic [10:0] VDC,
    // Ramp steering outputs
    input wire logic RAMP_HOLD,
    input wire logic RAMP_ACCEL,
    input wire logic [11:0] ACCEL_RATE,
    input wire logic signed [15:0] FREQ_LIFT,
    input wire logic GUARD_ACTIVE
);
    // ----------------------------------------------------------
    // Clocking and sequences
    // ----------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    // Guard engaged, then the ramp generator drops the decel request
    sequence disarm_s;
        GUARD_ACTIVE ##1 !DECEL_ACTIVE;
    endsequence

    // Boosting with no fresh sample to act on
    sequence held_boost_s;
        RAMP_ACCEL && DECEL_ACTIVE && !VDC_VALID;
    endsequence

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not zero-wait okay");
    disarm_clear_a: assert property (
        disarm_s |=> !GUARD_ACTIVE && !RAMP_HOLD && !RAMP_ACCEL)
        else $error("steering not cleared after disarm");
    idle_quiet_a: assert property (
        !DECEL_ACTIVE [*2] |-> FREQ_LIFT == 16'sh0000 && ACCEL_RATE == 12'h000)
        else $error("lift or rate while no decel ramp");
    rate_range_a: assert property (
        RAMP_ACCEL ? (ACCEL_RATE >= ACCEL_MIN && ACCEL_RATE <= ACCEL_MAX)
                   : ACCEL_RATE == 12'h000)
        else $error("accel rate out of range or not zero");
    boost_hold_a: assert property (
        RAMP_ACCEL |-> RAMP_HOLD && GUARD_ACTIVE)
        else $error("accelerating without hold");
    boost_entry_a: assert property (
        $rose(RAMP_ACCEL) |-> $past(VDC_VALID) && $past(DECEL_ACTIVE))
        else $error("boost entered without an armed sample");
    boost_exit_a: assert property (
        $fell(RAMP_ACCEL) |-> $past(VDC_VALID) || !$past(DECEL_ACTIVE))
        else $error("boost left without a sample");
    boost_stand_a: assert property (
        held_boost_s |=> RAMP_ACCEL)
        else $error("boost dropped between samples");
    lift_mode_a: assert property (
        FREQ_LIFT != 16'sh0000 |-> GUARD_ACTIVE && !RAMP_ACCEL)
        else $error("lift outside regulation");
    lift_latency_a: assert property (
        FREQ_LIFT != $past(FREQ_LIFT) |->
            $past(VDC_VALID, 2) || FREQ_LIFT == 16'sh0000)
        else $error("lift changed without a sample two edges back");
endmodule

bind decel_overvoltage_guard decel_overvoltage_guard_props u_props (
    .CLK(CLK), .RST_B(RST_B), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .DECEL_ACTIVE(DECEL_ACTIVE), .VDC_VALID(VDC_VALID), .VDC(VDC),
    .RAMP_HOLD(RAMP_HOLD), .RAMP_ACCEL(RAMP_ACCEL),
    .ACCEL_RATE(ACCEL_RATE), .FREQ_LIFT(FREQ_LIFT),
    .GUARD_ACTIVE(GUARD_ACTIVE)
);

// >>> sim/ovp_power_stage.sv
// Behavioural power stage: decel ramp flag and periodic DC link samples
`timescale 1ns/100ps
module ovp_power_stage (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Scenario control
    input wire logic decel_cmd,
    input wire logic [10:0] vdc_level,
    input wire logic [7:0] period,
    // Toward the guard
    output logic decel_active,
    output logic vdc_valid,
    output logic [10:0] vdc
);
    logic [7:0] cnt;

    // Period 0 stops sampling; outside a pulse the bus shows junk,
    // so a guard that samples off the strobe is caught
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 8'h00;
            vdc_valid <= 1'b0;
            vdc <= 11'h000;
            decel_active <= 1'b0;
        end else begin
            decel_active <= decel_cmd;
            if (period != 8'h00 && cnt >= period - 8'h01) begin
                cnt <= 8'h00;
                vdc_valid <= 1'b1;
                vdc <= vdc_level;
            end else begin
                cnt <= cnt + 8'h01;
                vdc_valid <= 1'b0;
                vdc <= ~vdc_level;
            end
        end
    end
endmodule

// >>> sim/decel_overvoltage_guard_tb.sv
// Self-checking bench for the deceleration overvoltage guard
`timescale 1ns/100ps
module decel_overvoltage_guard_tb import ovp_pkg::*; ;
    logic clk, rst_b, hsel, hwrite, class_400, decel_cmd;
    logic [7:0] haddr, period;
    logic [1:0] htrans;
    logic [31:0] hwdata, rd;
    logic [10:0] vdc_level, vdc;
    wire logic hreadyout, hresp, decel_active, vdc_valid;
    wire logic ramp_hold, ramp_accel, guard_active;
    wire logic [31:0] hrdata;
    wire logic [11:0] accel_rate;
    wire logic signed [15:0] freq_lift;
    int bad_count = 0;
    int cmp_count = 0;

    // ----------------------------------------------------------
    // Clock, design and partner
    // ----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    decel_overvoltage_guard DUT (.CLK(clk), .RST_B(rst_b), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
        .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
        .HRDATA(hrdata), .HRESP(hresp), .CLASS_400(class_400),
        .DECEL_ACTIVE(decel_active), .VDC_VALID(vdc_valid), .VDC(vdc),
        .RAMP_HOLD(ramp_hold), .RAMP_ACCEL(ramp_accel),
        .ACCEL_RATE(accel_rate), .FREQ_LIFT(freq_lift),
        .GUARD_ACTIVE(guard_active));

    ovp_power_stage stage (.clk(clk), .rst_b(rst_b), .decel_cmd(decel_cmd),
        .vdc_level(vdc_level), .period(period),
        .decel_active(decel_active), .vdc_valid(vdc_valid), .vdc(vdc));

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Address phase held until ready, then data phase until ready
    task automatic bus_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        bus_xfer(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Strap is sampled at the first edge after release
    task automatic do_reset(input logic cls);
        @(posedge clk);
        rst_b <= 1'b0;
        class_400 <= cls;
        decel_cmd <= 1'b0;
        period <= 8'h00;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic test_registers;
        reg_check(OFS_MODE, 32'h0000_0001);
        reg_check(OFS_LEVEL, 32'h0000_017C);
        reg_check(OFS_ACCEL, 32'h0000_0064);
        reg_check(OFS_GAIN, 32'h0000_0032);
        reg_check(OFS_ITIME, 32'h0000_003C);
        bus_xfer(1'b1, 8'h18, 32'hFFFF_FFFF);
        reg_check(8'h18, 32'h0000_0000);
        bus_xfer(1'b1, OFS_MODE, 32'h0000_0003);
        reg_check(OFS_MODE, 32'h0000_0001);
        bus_xfer(1'b1, OFS_LEVEL, 32'h0000_012C);
        reg_check(OFS_LEVEL, 32'h0000_014A);
        bus_xfer(1'b1, OFS_LEVEL, 32'h0000_01F4);
        reg_check(OFS_LEVEL, 32'h0000_0186);
        bus_xfer(1'b1, OFS_ACCEL, 32'h0000_0005);
        reg_check(OFS_ACCEL, 32'h0000_000A);
        bus_xfer(1'b1, OFS_ACCEL, 32'h0000_0FA0);
        reg_check(OFS_ACCEL, 32'h0000_0BB8);
        bus_xfer(1'b1, OFS_GAIN, 32'h0000_00FF);
        reg_check(OFS_GAIN, 32'h0000_00FF);
        bus_xfer(1'b1, OFS_ITIME, 32'h0000_FFFF);
        reg_check(OFS_ITIME, 32'h0000_FFFF);
        do_reset(1'b1);
        reg_check(OFS_LEVEL, 32'h0000_02F8);
        bus_xfer(1'b1, OFS_LEVEL, 32'h0000_0258);
        reg_check(OFS_LEVEL, 32'h0000_0294);
        bus_xfer(1'b1, OFS_LEVEL, 32'h0000_0384);
        reg_check(OFS_LEVEL, 32'h0000_030C);
        do_reset(1'b0);
        $display("test registers done");
    endtask

    // Mode 0 ignores overvoltage; mode 2 boosts and returns
    task automatic test_accel_mode;
        bus_xfer(1'b1, OFS_MODE, 32'h0000_0000);
        vdc_level <= 11'd400;
        period <= 8'h02;
        decel_cmd <= 1'b1;
        settle(10);
        check({31'h0, guard_active | ramp_accel}, 32'h0);
        decel_cmd <= 1'b0;
        bus_xfer(1'b1, OFS_MODE, 32'h0000_0002);
        bus_xfer(1'b1, OFS_ACCEL, 32'h0000_0096);
        period <= 8'h04;
        decel_cmd <= 1'b1;
        settle(10);
        check({ramp_accel, ramp_hold, accel_rate}, 32'h0000_3096);
        // No lift outside regulation, last armed sample 400 V, boost state
        reg_check(OFS_STATUS, 32'h0000_320F);
        vdc_level <= 11'd380;
        settle(10);
        check({31'h0, ramp_accel}, 32'h1);
        vdc_level <= 11'd370;
        settle(6);
        check({guard_active, ramp_accel, accel_rate},
              32'h0000_2000);
        vdc_level <= 11'd381;
        settle(6);
        check({31'h0, ramp_accel}, 32'h1);
        decel_cmd <= 1'b0;
        period <= 8'h00;
        settle(3);
        check({30'h0, guard_active, ramp_accel}, 32'h0);
        $display("test accel mode done");
    endtask

    // Gain 1.00, integral time 1 ms: lift grows by err per sample
    task automatic test_const_mode;
        int n;
        bus_xfer(1'b1, OFS_MODE, 32'h0000_0001);
        bus_xfer(1'b1, OFS_GAIN, 32'h0000_0064);
        bus_xfer(1'b1, OFS_ITIME, 32'h0000_0001);
        vdc_level <= 11'd390;
        decel_cmd <= 1'b1;
        settle(4);
        check({guard_active, ramp_accel, freq_lift},
              32'h0002_0000);
        period <= 8'h08;
        n = 0;
        while (n < 2) begin
            @(posedge clk);
            if (vdc_valid === 1'b1) n++;
        end
        period <= 8'h00;
        settle(3);
        check({16'h0, freq_lift}, 32'h0000_0014);
        check({31'h0, ramp_hold}, 32'h1);
        bus_xfer(1'b1, OFS_GAIN, 32'h0000_0032);
        bus_xfer(1'b1, OFS_ITIME, 32'h0000_0000);
        vdc_level <= 11'd370;
        period <= 8'h08;
        @(posedge clk);
        while (vdc_valid !== 1'b1) @(posedge clk);
        period <= 8'h00;
        settle(3);
        check({ramp_hold, freq_lift}, 32'h0000_FFFB);
        settle(200);
        check({31'h0, guard_active}, 32'h1);
        decel_cmd <= 1'b0;
        settle(3);
        check({guard_active, freq_lift}, 32'h0);
        $display("test const mode done");
    endtask

    // ----------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 8'h00;
        hwdata = 32'h0;
        class_400 = 1'b0;
        decel_cmd = 1'b0;
        vdc_level = 11'd0;
        period = 8'h00;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        test_registers;
        test_accel_mode;
        test_const_mode;
        complete_run;
    end

    // A few hundred cycles are expected; far beyond means a hang
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run;
    end
endmodule
